// ===== shared/input_select_pkg.sv
// constants for the input selector and scan settings bank
// assumes a 4-bit register index from the serial command decoder
`default_nettype none
package input_select_pkg;

    // register indices and widths
    localparam logic [3:0]  SEL_ADDR        = 4'h6;
    localparam logic [3:0]  SCAN_ADDR       = 4'h7;
    localparam int          SEL_WIDTH       = 8;
    localparam int          SCAN_WIDTH      = 24;

    // reset values at power-on
    localparam logic [7:0]  SEL_RESET       = 8'h01;
    localparam logic [23:0] SCAN_RESET      = 24'h000000;

    // field positions
    localparam int          POS_SEL_LSB     = 4;
    localparam int          NEG_SEL_LSB     = 0;
    localparam int          GAP_LSB         = 21;
    localparam int          GAP_RSVD_BIT    = 20;
    localparam int          SPECIAL_LSB     = 12;
    localparam int          DIFF_LSB        = 8;
    localparam int          SE_LSB          = 0;

    // bits 19..16 are unimplemented and hold zero
    localparam logic [23:0] SCAN_WRITABLE   = 24'hF0FFFF;

    // input codes
    localparam logic [3:0]  CODE_AGND       = 4'h8;
    localparam logic [3:0]  CODE_AVDD       = 4'h9;
    localparam logic [3:0]  CODE_RESERVED   = 4'hA;
    localparam logic [3:0]  CODE_REF_POS    = 4'hB;
    localparam logic [3:0]  CODE_REF_NEG    = 4'hC;
    localparam logic [3:0]  CODE_DIODE_P    = 4'hD;
    localparam logic [3:0]  CODE_DIODE_M    = 4'hE;
    localparam logic [3:0]  CODE_CM         = 4'hF;

    // shortest non-zero gap, in modulator clock periods
    localparam logic [9:0]  GAP_MIN_PERIODS = 10'h008;

    typedef enum logic [3:0] {
        SRC_CHANNEL, SRC_AGND, SRC_AVDD, SRC_RESERVED, SRC_REF_POS,
        SRC_REF_NEG, SRC_DIODE_P, SRC_DIODE_M, SRC_COMMON_MODE
    } source_type;

    // maps a 4-bit select code onto the analog source it routes
    function automatic source_type decode_source(input logic [3:0] code);
        source_type s;
        s = SRC_CHANNEL;
        case (code)
            CODE_AGND:     s = SRC_AGND;
            CODE_AVDD:     s = SRC_AVDD;
            CODE_RESERVED: s = SRC_RESERVED;
            CODE_REF_POS:  s = SRC_REF_POS;
            CODE_REF_NEG:  s = SRC_REF_NEG;
            CODE_DIODE_P:  s = SRC_DIODE_P;
            CODE_DIODE_M:  s = SRC_DIODE_M;
            CODE_CM:       s = SRC_COMMON_MODE;
            default:       s = SRC_CHANNEL;
        endcase
        return s;
    endfunction

    // gap length: 0 for code 0, else 8 doubled per step up to 512
    function automatic logic [9:0] gap_periods(input logic [2:0] code);
        logic [9:0] p;
        p = 10'h000;
        if (code != 3'h0)
        begin
            p = GAP_MIN_PERIODS << (code - 3'h1);
        end
        return p;
    endfunction

endpackage
`default_nettype wire

// ===== rtl/scan_gap_timer.sv
// waits the scan gap between two conversions
// assumes start comes from logic on clk; modulator tick is divided here
`timescale 1ns/1ns
`default_nettype none
module scan_gap_timer #(
    parameter int MOD_DIV = 4
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // request
    input  wire logic       start,
    input  wire logic [2:0] gap_code,
    // status
    output logic            busy,
    output logic            done
);

    // a divider wider than 16 bits would wrap before its tick
    if (MOD_DIV < 1 || MOD_DIV > 65536)
    begin : g_bad_div
        $error("MOD_DIV must lie between 1 and 65536");
    end

    logic [15:0] div_r;
    logic [15:0] div_nxt;
    logic        tick;
    logic [9:0]  remaining_r;
    logic [9:0]  remaining_nxt;
    logic        busy_r;
    logic        busy_nxt;
    logic        done_r;
    logic        done_nxt;
    logic [9:0]  periods;

    assign periods = input_select_pkg::gap_periods(gap_code);
    assign busy    = busy_r;
    assign done    = done_r;

    // modulator clock as an enable; free running so gaps align to its edges
    always_comb
    begin
        tick          = (div_r == 16'(MOD_DIV - 1));
        div_nxt       = tick ? 16'h0000 : div_r + 16'h0001;
        remaining_nxt = remaining_r;
        busy_nxt      = busy_r;
        done_nxt      = 1'b0;
        if (start && !busy_r)
        begin
            if (periods == 10'h000)
            begin
                done_nxt = 1'b1;
            end
            else
            begin
                remaining_nxt = periods;
                busy_nxt      = 1'b1;
            end
        end
        else if (busy_r && tick)
        begin
            if (remaining_r == 10'h001)
            begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
            remaining_nxt = remaining_r - 10'h001;
        end
    end

    // state registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_r       <= 16'h0000;
            remaining_r <= 10'h000;
            busy_r      <= 1'b0;
            done_r      <= 1'b0;
        end
        else
        begin
            div_r       <= div_nxt;
            remaining_r <= remaining_nxt;
            busy_r      <= busy_nxt;
            done_r      <= done_nxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_gap_load;
        start && !busy_r && gap_code != 3'h0 |=>
            busy_r && remaining_r == input_select_pkg::gap_periods($past(gap_code));
    endproperty
    a_gap_load: assert property (p_gap_load) else $error("gap length not loaded");

    property p_gap_zero;
        start && !busy_r && gap_code == 3'h0 |=> done_r && !busy_r;
    endproperty
    a_gap_zero: assert property (p_gap_zero) else $error("zero gap not immediate");

    property p_gap_end;
        busy_r && tick && remaining_r == 10'h001 |=> done_r && !busy_r;
    endproperty
    a_gap_end: assert property (p_gap_end) else $error("gap did not end");

    property p_gap_longest;
        start && !busy_r && gap_code == 3'h7 |=> busy_r && remaining_r == 10'h200;
    endproperty
    c_gap_longest: cover property (p_gap_longest);

endmodule // scan_gap_timer
`default_nettype wire

// ===== rtl/input_select_bank.sv
// input selector and scan settings registers, with scan gap timing
// assumes the serial command decoder drives the register port on clk
// How it works
// - 8-bit select register at 0x6, two nibbles
// - codes route channels, ground, supply, references, common-mode
// - codes D and E route temperature diode
// - diode selected turns on bias current
// - 24-bit scan register at 0x7 with fields
// - gap code gives 0 periods for code 0, else 8 to 512 periods
`timescale 1ns/1ns
`default_nettype none
module input_select_bank #(
    parameter int MOD_DIV = 4
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    // register port from the serial decoder
    input  wire logic [3:0]                    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [23:0]                   reg_wdata,
    input  wire logic                          reg_rd,
    output logic      [23:0]                   reg_rdata,
    output logic                               reg_rvalid,
    // front-end selection
    output input_select_pkg::source_type       pos_source,
    output logic      [2:0]                    pos_channel,
    output input_select_pkg::source_type       neg_source,
    output logic      [2:0]                    neg_channel,
    output logic                               temp_bias_en,
    // scan settings
    output logic      [2:0]                    scan_gap_delay,
    output logic      [3:0]                    special_scan_mask,
    output logic      [3:0]                    differential_scan_mask,
    output logic      [7:0]                    single_ended_scan_mask,
    // scan gap timing
    input  wire logic                          gap_start,
    output logic                               gap_busy,
    output logic                               gap_done
);

    logic [7:0]  sel_r;
    logic [7:0]  sel_nxt;
    logic [23:0] scan_r;
    logic [23:0] scan_nxt;
    logic [23:0] rdata_r;
    logic [23:0] rdata_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic        bias_r;
    logic        bias_nxt;
    logic [3:0]  pos_code;
    logic [3:0]  neg_code;

    // register writes; unimplemented scan bits are masked at the store
    always_comb
    begin
        sel_nxt  = sel_r;
        scan_nxt = scan_r;
        if (reg_wr && reg_addr == input_select_pkg::SEL_ADDR)
        begin
            sel_nxt = reg_wdata[7:0];
        end
        if (reg_wr && reg_addr == input_select_pkg::SCAN_ADDR)
        begin
            scan_nxt = reg_wdata & input_select_pkg::SCAN_WRITABLE;
        end
        // bias follows the value being stored so it never lags the route
        bias_nxt = (sel_nxt[7:4] == input_select_pkg::CODE_DIODE_P)
                || (sel_nxt[7:4] == input_select_pkg::CODE_DIODE_M)
                || (sel_nxt[3:0] == input_select_pkg::CODE_DIODE_P)
                || (sel_nxt[3:0] == input_select_pkg::CODE_DIODE_M);
    end

    // read path; unmapped indices answer zero
    always_comb
    begin
        rvalid_nxt = reg_rd;
        rdata_nxt  = rdata_r;
        if (reg_rd)
        begin
            case (reg_addr)
                input_select_pkg::SEL_ADDR:  rdata_nxt = {16'h0000, sel_r};
                input_select_pkg::SCAN_ADDR: rdata_nxt = scan_r;
                default:                     rdata_nxt = 24'h000000;
            endcase
        end
    end

    // register state
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_r    <= input_select_pkg::SEL_RESET;
            scan_r   <= input_select_pkg::SCAN_RESET;
            rdata_r  <= 24'h000000;
            rvalid_r <= 1'b0;
            bias_r   <= 1'b0;
        end
        else
        begin
            sel_r    <= sel_nxt;
            scan_r   <= scan_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            bias_r   <= bias_nxt;
        end
    end

    // route decode straight from the stored codes
    assign pos_code     = sel_r[input_select_pkg::POS_SEL_LSB +: 4];
    assign neg_code     = sel_r[input_select_pkg::NEG_SEL_LSB +: 4];
    assign pos_source   = input_select_pkg::decode_source(pos_code);
    assign neg_source   = input_select_pkg::decode_source(neg_code);
    assign pos_channel  = pos_code[2:0];
    assign neg_channel  = neg_code[2:0];
    assign temp_bias_en = bias_r;
    assign reg_rdata    = rdata_r;
    assign reg_rvalid   = rvalid_r;

    // scan fields
    assign scan_gap_delay         = scan_r[input_select_pkg::GAP_LSB +: 3];
    assign special_scan_mask      = scan_r[input_select_pkg::SPECIAL_LSB +: 4];
    assign differential_scan_mask = scan_r[input_select_pkg::DIFF_LSB +: 4];
    assign single_ended_scan_mask = scan_r[input_select_pkg::SE_LSB +: 8];

    // gap timer uses the stored code at the moment of start
    scan_gap_timer #(
        .MOD_DIV (MOD_DIV)
    ) u_gap (
        .clk      (clk),
        .rst_b    (rst_b),
        .start    (gap_start),
        .gap_code (scan_gap_delay),
        .busy     (gap_busy),
        .done     (gap_done)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_sel_readback;
        reg_wr && reg_addr == 4'h6 ##1 !reg_wr ##1 reg_rd && reg_addr == 4'h6 && !reg_wr
            |=> reg_rvalid && reg_rdata == {16'h0000, $past(reg_wdata[7:0], 3)};
    endproperty
    a_sel_readback: assert property (p_sel_readback) else $error("select readback wrong");

    property p_route_fixed;
        sel_r[7:4] == 4'h8 |-> pos_source == input_select_pkg::SRC_AGND;
    endproperty
    a_route_fixed: assert property (p_route_fixed) else $error("ground route wrong");

    property p_route_channel;
        sel_r[3] == 1'b0 |-> neg_source == input_select_pkg::SRC_CHANNEL && neg_channel == sel_r[2:0];
    endproperty
    a_route_channel: assert property (p_route_channel) else $error("channel route wrong");

    property p_route_diode;
        sel_r == 8'hDE |-> pos_source == input_select_pkg::SRC_DIODE_P
            && neg_source == input_select_pkg::SRC_DIODE_M;
    endproperty
    a_route_diode: assert property (p_route_diode) else $error("diode route wrong");

    property p_bias;
        temp_bias_en == (sel_r[7:4] == 4'hD || sel_r[7:4] == 4'hE
            || sel_r[3:0] == 4'hD || sel_r[3:0] == 4'hE);
    endproperty
    a_bias: assert property (p_bias) else $error("bias source wrong");

    property p_scan_write;
        reg_wr && reg_addr == 4'h7 |=> scan_gap_delay == $past(reg_wdata[23:21])
            && single_ended_scan_mask == $past(reg_wdata[7:0])
            && differential_scan_mask == $past(reg_wdata[11:8]);
    endproperty
    a_scan_write: assert property (p_scan_write) else $error("scan fields wrong");

    property p_unimpl_zero;
        reg_rvalid && $past(reg_addr) == 4'h7 |-> reg_rdata[19:16] == 4'h0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("bits 19-16 not zero");

    property p_temp_setup;
        reg_wr && reg_addr == 4'h6 && reg_wdata[7:0] == 8'hDE;
    endproperty
    c_temp_setup: cover property (p_temp_setup);

    property p_scan_read;
        reg_rvalid && scan_r != 24'h000000;
    endproperty
    c_scan_read: cover property (p_scan_read);

    property p_gap_finish;
        gap_busy ##1 gap_done;
    endproperty
    c_gap_finish: cover property (p_gap_finish);

endmodule // input_select_bank
`default_nettype wire

// ===== test/host_model.sv
// host controller model driving the register port of the selector bank
// assumes the bench calls its tasks and that the bank answers reads after one edge
`timescale 1ns/1ns
`default_nettype none
module host_model #(
    parameter int CHANNELS = 8
) (
    // clock
    input  wire logic        clk,
    // register port toward the bank
    output logic      [3:0]  reg_addr,
    output logic             reg_wr,
    output logic      [23:0] reg_wdata,
    output logic             reg_rd,
    input  wire logic [23:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    // idle values at time zero
    initial
    begin
        reg_addr  = 4'h0;
        reg_wr    = 1'b0;
        reg_wdata = 24'h5A5A5A;
        reg_rd    = 1'b0;
    end

    // one write; released lines show the inverse so stale data never looks valid
    task automatic write_reg(input logic [3:0] a, input logic [23:0] d);
        logic [23:0] v;
        v = d;
        if (a == input_select_pkg::SCAN_ADDR) v[input_select_pkg::GAP_RSVD_BIT] = 1'b0;
        if (a == input_select_pkg::SEL_ADDR && !v[7] && int'(v[6:4]) >= CHANNELS) v[7:4] = 4'h8;
        if (a == input_select_pkg::SEL_ADDR && !v[3] && int'(v[2:0]) >= CHANNELS) v[3:0] = 4'h8;
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~v;
    endtask

    // one read; answer sampled mid-cycle after the answering edge
    task automatic read_reg(input logic [3:0] a, output logic [23:0] d, output logic ok);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk);
        d  = reg_rdata;
        ok = reg_rvalid;
    endtask
endmodule // host_model
`default_nettype wire

// ===== test/test_input_select_bank.sv
// self-checking bench for the input selector and scan settings bank
// assumes MOD_DIV of 1 so each gap lasts exactly its period count in clocks
`timescale 1ns/1ns
`default_nettype none
module test_input_select_bank;
    logic                          clk;
    logic                          rst_b;
    logic                          gap_start;
    logic [3:0]                    reg_addr;
    logic                          reg_wr;
    logic [23:0]                   reg_wdata;
    logic                          reg_rd;
    logic [23:0]                   reg_rdata;
    logic                          reg_rvalid;
    input_select_pkg::source_type  pos_source;
    input_select_pkg::source_type  neg_source;
    logic [2:0]                    pos_channel;
    logic [2:0]                    neg_channel;
    logic                          temp_bias_en;
    logic [2:0]                    scan_gap_delay;
    logic [3:0]                    special_scan_mask;
    logic [3:0]                    differential_scan_mask;
    logic [7:0]                    single_ended_scan_mask;
    logic                          gap_busy;
    logic                          gap_done;
    int                            bad_count;
    int                            total_checks;
    int                            cycles;
    logic [23:0]                   d;
    logic [23:0]                   r;
    logic [7:0]                    w;
    logic                          ok;
    int                            n;

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    host_model #(.CHANNELS(8)) u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    input_select_bank #(.MOD_DIV(1)) u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pos_source(pos_source), .pos_channel(pos_channel), .neg_source(neg_source), .neg_channel(neg_channel),
        .temp_bias_en(temp_bias_en), .scan_gap_delay(scan_gap_delay), .special_scan_mask(special_scan_mask),
        .differential_scan_mask(differential_scan_mask), .single_ended_scan_mask(single_ended_scan_mask),
        .gap_start(gap_start), .gap_busy(gap_busy), .gap_done(gap_done));

    task automatic check_value(input string name, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // source each select code should route
    function automatic logic [3:0] exp_src(input logic [3:0] c);
        case (c)
            4'h8: return input_select_pkg::SRC_AGND;
            4'h9: return input_select_pkg::SRC_AVDD;
            4'hA: return input_select_pkg::SRC_RESERVED;
            4'hB: return input_select_pkg::SRC_REF_POS;
            4'hC: return input_select_pkg::SRC_REF_NEG;
            4'hD: return input_select_pkg::SRC_DIODE_P;
            4'hE: return input_select_pkg::SRC_DIODE_M;
            4'hF: return input_select_pkg::SRC_COMMON_MODE;
            default: return input_select_pkg::SRC_CHANNEL;
        endcase
    endfunction

    // clocks from start to done: one to register done, plus the gap periods
    function automatic logic [23:0] gap_len(input logic [2:0] c);
        return (c == 3'h0) ? 24'h000001 : (24'h000200 >> (3'h7 - c)) + 24'h000001;
    endfunction

    // select write then check every front-end output and the read-back
    task automatic sel_case(input logic [7:0] v);
        u_host.write_reg(input_select_pkg::SEL_ADDR, {16'hFFFF, v});
        @(negedge clk);
        check_value("pos_source", 24'(pos_source), 24'(exp_src(v[7:4])));
        check_value("neg_source", 24'(neg_source), 24'(exp_src(v[3:0])));
        check_value("channels", {18'h0, pos_channel, neg_channel}, {18'h0, v[6:4], v[2:0]});
        check_value("temp_bias_en", 24'(temp_bias_en), 24'(v[7:4] == 4'hD || v[7:4] == 4'hE
            || v[3:0] == 4'hD || v[3:0] == 4'hE ? 1 : 0));
        u_host.read_reg(input_select_pkg::SEL_ADDR, d, ok);
        check_value("sel_read", d, {16'h0, v});
    endtask

    // hang guard, far above the roughly 1200 cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    initial
    begin
        rst_b = 1'b0;
        gap_start = 1'b0;
        bad_count = 0;
        total_checks = 0;
        cycles = 0;
        void'($urandom(51));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        u_host.read_reg(input_select_pkg::SEL_ADDR, d, ok);
        check_value("sel_reset", d, 24'h000001);
        check_value("rvalid", 24'(ok), 24'h000001);
        u_host.read_reg(input_select_pkg::SCAN_ADDR, d, ok);
        check_value("scan_reset", d, 24'h000000);
        // every code on both nibbles, temperature pairings included
        for (int i = 0; i < 16; i++)
        begin
            w = {4'(i), ~4'(i)};
            sel_case(w);
        end
        sel_case(8'hDE);
        // unmapped index: write ignored, read zero
        u_host.write_reg(4'h3, 24'(32'($urandom)));
        u_host.read_reg(4'h3, d, ok);
        check_value("unmapped_read", d, 24'h000000);
        u_host.read_reg(input_select_pkg::SEL_ADDR, d, ok);
        check_value("sel_kept", d, 24'h0000DE);
        // random scan words; bits 19..16 must read zero whatever was sent
        repeat (10)
        begin
            r = 24'($urandom) & 24'hEFFFFF;
            u_host.write_reg(input_select_pkg::SCAN_ADDR, r);
            @(negedge clk);
            check_value("scan_fields", {scan_gap_delay, 5'h0, special_scan_mask, differential_scan_mask,
                single_ended_scan_mask}, r & 24'hE0FFFF);
            u_host.read_reg(input_select_pkg::SCAN_ADDR, d, ok);
            check_value("scan_read", d, r & 24'hE0FFFF);
        end
        // every gap code, timed from the start edge to done
        for (int c = 0; c < 8; c++)
        begin
            u_host.write_reg(input_select_pkg::SCAN_ADDR, {3'(c), 21'h0});
            @(posedge clk);
            gap_start <= 1'b1;
            @(posedge clk);
            gap_start <= 1'b0;
            n = 1;
            @(negedge clk);
            check_value("gap_busy", 24'(gap_busy), 24'(c != 0));
            while (gap_done !== 1'b1 && n < 600)
            begin
                @(negedge clk);
                n++;
            end
            check_value("gap_cycles", 24'(n), gap_len(3'(c)));
            check_value("gap_idle", 24'(gap_busy), 24'h000000);
        end
        report_and_stop();
    end
endmodule // test_input_select_bank
`default_nettype wire
